// file: logic/kpsr_pkg.sv
/*
  Shared constants for the keypad serial receive port.
  Assumes a single 250 MHz clock domain.
*/
package kpsr_pkg;
  localparam int          KPSR_DATA_W     = 8;
  localparam int          KPSR_CNT_W      = 8;
  localparam int          KPSR_FIFO_DEPTH = 16;
  localparam int          KPSR_BIT_MSB    = 7;
  localparam logic [2:0]  KPSR_BIT_LAST   = 3'h7;
  localparam int          KPSR_MODE_LSB   = 5;
  localparam int          KPSR_MODE_FALL  = 3;
  localparam int          KPSR_MODE_AFTER = 2;
  localparam logic [7:0]  KPSR_MODE_RST   = 8'h00;
  localparam logic [7:0]  KPSR_PKT_RST    = 8'h04;
  localparam logic [7:0]  KPSR_BUF_RST    = 8'h05;
  localparam logic [7:0]  KPSR_CNT_ONE    = 8'h01;
  localparam logic [7:0]  KPSR_CNT_ZERO   = 8'h00;
  localparam logic [2:0]  KPSR_BIT_ZERO   = 3'h0;
endpackage

// file: logic/kpsr_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides; read data
  is registered. Assumes one clock and a synchronous high reset.
*/
`timescale 1ns/1ps
module kpsr_fifo
  import kpsr_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [LW-1:0]    lvl_q, lvl_d;
  logic [WIDTH-1:0] dat_q, dat_d;
  logic             vld_q, vld_d;
  logic             push, pop, load;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb
  begin
    push  = in_valid_i && in_ready_o;
    load  = (lvl_q != '0) && (!vld_q || out_ready_i);
    pop   = vld_q && out_ready_i;
    wr_d  = push ? inc(wr_q) : wr_q;
    rd_d  = load ? inc(rd_q) : rd_q;
    lvl_d = lvl_q + LW'(push) - LW'(load);
    dat_d = load ? mem_q[rd_q] : dat_q;
    vld_d = load ? 1'b1 : (pop ? 1'b0 : vld_q);
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      lvl_q <= '0;
      vld_q <= 1'b0;
      dat_q <= '0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      lvl_q <= lvl_d;
      vld_q <= vld_d;
      dat_q <= dat_d;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (push)
      mem_q[wr_q] <= in_data_i;
  end

  assign in_ready_o  = (lvl_q != LW'(DEPTH));
  assign out_valid_o = vld_q;
  assign out_data_o  = dat_q;
  assign level_o     = lvl_q;
endmodule

// file: logic/kpsr_top.sv
/*
  Keypad serial receive port: slave-mode four-wire serial receiver
  with a byte buffer and a packet interrupt.
  Assumes serial pins are asynchronous to clock_i and that the
  serial clock is far slower than clock_i (bench: 48 ns period).
*/
`timescale 1ns/1ps
module kpsr_top
  import kpsr_pkg::*;
#(
  parameter int DEPTH = KPSR_FIFO_DEPTH
)
(
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  input  wire logic                  port_en_i,
  input  wire logic [7:0]            mode_i,
  input  wire logic [KPSR_CNT_W-1:0] packet_i,
  input  wire logic [KPSR_CNT_W-1:0] bufsize_i,
  input  wire logic                  glob_en_set_i,
  input  wire logic                  glob_en_clr_i,
  input  wire logic                  pad_en_set_i,
  input  wire logic                  pad_en_clr_i,
  input  wire logic                  sck_i,
  input  wire logic                  ss_n_i,
  input  wire logic                  mosi_i,
  output logic                       miso_o,
  output logic                       miso_oe_o,
  output logic                       sck_oe_o,
  output logic                       ss_oe_o,
  output logic                       mosi_oe_o,
  output logic                       rx_valid_o,
  input  wire logic                  rx_ready_i,
  output logic [KPSR_DATA_W-1:0]     rx_data_o,
  output logic [KPSR_CNT_W-1:0]      rx_count_o,
  output logic                       drop_o,
  output logic                       irq_o,
  output logic                       glob_en_o,
  output logic                       pad_en_o
);
  localparam int LW = $clog2(DEPTH+1);

  //////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] sck_s_q, ss_s_q, mosi_s_q;
  logic       sck_old_q;

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      sck_s_q   <= 2'h0;
      ss_s_q    <= 2'h3;
      mosi_s_q  <= 2'h0;
      sck_old_q <= 1'b0;
    end
    else
    begin
      sck_s_q   <= {sck_s_q[0], sck_i};
      ss_s_q    <= {ss_s_q[0], ss_n_i};
      mosi_s_q  <= {mosi_s_q[0], mosi_i};
      sck_old_q <= sck_s_q[1];
    end
  end

  //////////////////////////////////////////////////////////////////
  // Mode decode and bit capture

  logic cfg_lsb, cfg_fall, cfg_after;
  logic edge_rise, edge_fall, act_edge, other_edge, take;
  logic sel;
  logic [7:0] mode_q, mode_d;

  // Edge of the synced serial clock
  function automatic logic edge_seen(input logic now_v,
                                     input logic old_v,
                                     input logic rising);
    edge_seen = rising ? (now_v && !old_v) : (!now_v && old_v);
  endfunction

  always_comb
  begin
    cfg_lsb    = mode_q[KPSR_MODE_LSB];
    cfg_fall   = mode_q[KPSR_MODE_FALL];
    cfg_after  = mode_q[KPSR_MODE_AFTER];
    edge_rise  = edge_seen(sck_s_q[1], sck_old_q, 1'b1);
    edge_fall  = edge_seen(sck_s_q[1], sck_old_q, 1'b0);
    act_edge   = cfg_fall ? edge_fall : edge_rise;
    other_edge = cfg_fall ? edge_rise : edge_fall;
    sel        = port_en_i && !ss_s_q[1];
    take       = sel && (cfg_after ? other_edge : act_edge);
  end

  //////////////////////////////////////////////////////////////////
  // Mode hold

  always_comb
  begin
    // Mode may not change under an open frame
    mode_d = sel ? mode_q : mode_i;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      mode_q <= KPSR_MODE_RST;
    else
      mode_q <= mode_d;
  end

  logic [7:0] shf_q, shf_d;
  logic [2:0] bit_q, bit_d;
  logic       byte_done;
  logic [7:0] byte_val;

  always_comb
  begin
    shf_d     = shf_q;
    bit_d     = bit_q;
    byte_done = 1'b0;
    byte_val  = shf_q;
    if (!sel)
      bit_d = KPSR_BIT_ZERO;
    else if (take)
    begin
      shf_d = cfg_lsb ? {mosi_s_q[1], shf_q[KPSR_BIT_MSB:1]}
                      : {shf_q[KPSR_BIT_MSB-1:0], mosi_s_q[1]};
      bit_d = bit_q + 3'h1;
      if (bit_q == KPSR_BIT_LAST)
      begin
        byte_done = 1'b1;
        byte_val  = shf_d;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      shf_q <= 8'h00;
      bit_q <= KPSR_BIT_ZERO;
    end
    else
    begin
      shf_q <= shf_d;
      bit_q <= bit_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Receive buffer

  logic          f_ready;
  logic [LW-1:0] f_level;
  logic [LW:0]   occ;
  logic          buf_room, push;

  always_comb
  begin
    // Output register holds a byte too
    occ      = (LW+1)'(f_level) + (LW+1)'(rx_valid_o);
    buf_room = f_ready && (KPSR_CNT_W'(occ) < bufsize_i);
    push     = byte_done && buf_room;
  end

  kpsr_fifo #(
    .WIDTH (KPSR_DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .in_valid_i  (push),
    .in_ready_o  (f_ready),
    .in_data_i   (byte_val),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o),
    .level_o     (f_level)
  );

  //////////////////////////////////////////////////////////////////
  // Packet count, enables and interrupt

  logic [7:0] pkt_q, pkt_d;
  logic       drop_q, drop_d;
  logic       irq_q, irq_d;
  logic       glob_q, glob_d;
  logic       pad_q, pad_d;
  logic       pkt_hit;

  // Packet counter step
  function automatic logic [KPSR_CNT_W-1:0] cnt_step(
    input logic [KPSR_CNT_W-1:0] c
  );
    cnt_step = c + KPSR_CNT_ONE;
  endfunction

  always_comb
  begin
    pkt_d   = pkt_q;
    pkt_hit = 1'b0;
    drop_d  = byte_done && !buf_room;
    if (!port_en_i)
      pkt_d = KPSR_CNT_ZERO;
    else if (push)
    begin
      if (cnt_step(pkt_q) >= packet_i)
      begin
        pkt_d   = KPSR_CNT_ZERO;
        pkt_hit = 1'b1;
      end
      else
        pkt_d = cnt_step(pkt_q);
    end
    irq_d  = pkt_hit && glob_q && pad_q;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      pkt_q  <= KPSR_CNT_ZERO;
      drop_q <= 1'b0;
      irq_q  <= 1'b0;
    end
    else
    begin
      pkt_q  <= pkt_d;
      drop_q <= drop_d;
      irq_q  <= irq_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Interrupt enables

  always_comb
  begin
    glob_d = glob_en_set_i ? 1'b1 : (glob_en_clr_i ? 1'b0 : glob_q);
    pad_d  = pad_en_set_i ? 1'b1 : (pad_en_clr_i ? 1'b0 : pad_q);
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      glob_q <= 1'b1;
      pad_q  <= 1'b1;
    end
    else
    begin
      glob_q <= glob_d;
      pad_q  <= pad_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Pin directions and outputs

  assign sck_oe_o   = 1'b0;
  assign ss_oe_o    = 1'b0;
  assign mosi_oe_o  = 1'b0;
  assign miso_oe_o  = sel;
  assign miso_o     = 1'b0;
  assign rx_count_o = KPSR_CNT_W'(occ);
  assign drop_o     = drop_q;
  assign irq_o      = irq_q;
  assign glob_en_o  = glob_q;
  assign pad_en_o   = pad_q;
endmodule

// file: testbench/kpsr_monitor.sv
/* Checker of kpsr_top port behaviour, bound to the top.
   Assumes one clock domain and a sync high reset. */
`timescale 1ns/1ps
module kpsr_monitor
(
  input wire logic       clock_i,
  input wire logic       reset_i,
  input wire logic       glob_en_set_i,
  input wire logic       glob_en_clr_i,
  input wire logic       pad_en_set_i,
  input wire logic       pad_en_clr_i,
  input wire logic       ss_n_i,
  input wire logic       rx_ready_i,
  input wire logic       miso_oe_o,
  input wire logic       sck_oe_o,
  input wire logic       rx_valid_o,
  input wire logic [7:0] rx_data_o,
  input wire logic       irq_o,
  input wire logic       drop_o,
  input wire logic       glob_en_o,
  input wire logic       pad_en_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  property p_dir; !sck_oe_o; endproperty
  a_dir: assert property (p_dir) else $error("sck pin driven");
  property p_oe; ss_n_i [*4] |-> !miso_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("miso unselected");
  property p_gon; glob_en_set_i |=> glob_en_o; endproperty
  a_gon: assert property (p_gon) else $error("glob not set");
  property p_goff;
    glob_en_clr_i && !glob_en_set_i |=> !glob_en_o;
  endproperty
  a_goff: assert property (p_goff) else $error("glob not clr");
  property p_poff;
    pad_en_clr_i && !pad_en_set_i |=> !pad_en_o;
  endproperty
  a_poff: assert property (p_poff) else $error("pad not clr");
  property p_gate; irq_o |-> $past(glob_en_o) && $past(pad_en_o); endproperty
  a_gate: assert property (p_gate) else $error("irq ungated");
  property p_irq1; irq_o |=> !irq_o; endproperty
  a_irq1: assert property (p_irq1) else $error("irq too long");
  property p_drop1; drop_o |=> !drop_o; endproperty
  a_drop1: assert property (p_drop1) else $error("drop too long");
  property p_hold;
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("rx data lost");
  c_irq: cover property (irq_o);
  c_drop: cover property (drop_o);
  c_take: cover property (rx_valid_o && rx_ready_i);
endmodule
bind kpsr_top kpsr_monitor kpsr_monitor_i (
  .clock_i       (clock_i),
  .reset_i       (reset_i),
  .glob_en_set_i (glob_en_set_i),
  .glob_en_clr_i (glob_en_clr_i),
  .pad_en_set_i  (pad_en_set_i),
  .pad_en_clr_i  (pad_en_clr_i),
  .ss_n_i        (ss_n_i),
  .rx_ready_i    (rx_ready_i),
  .miso_oe_o     (miso_oe_o),
  .sck_oe_o      (sck_oe_o),
  .rx_valid_o    (rx_valid_o),
  .rx_data_o     (rx_data_o),
  .irq_o         (irq_o),
  .drop_o        (drop_o),
  .glob_en_o     (glob_en_o),
  .pad_en_o      (pad_en_o)
);

// file: testbench/kpsr_pad_model.sv
/* Pad master model: drives serial clock, select and data.
   Assumes the receiver oversamples with a far faster clock. */
`timescale 1ns/1ps
module kpsr_pad_model
(
  output logic sck_o,
  output logic ss_n_o,
  output logic mosi_o
);
  initial
  begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b1;
  end
  task automatic send(input logic [7:0] d, input logic [7:0] m);
    int i;
    logic cap;
    cap = m[3] ^ m[2];
    sck_o = cap;
    #30 ss_n_o = 1'b0;
    for (i = 0; i < 8; i++)
    begin
      mosi_o = m[5] ? d[i] : d[7-i];
      #24 sck_o = !cap;
      #24 sck_o = cap;
    end
    #24 ss_n_o = 1'b1;
    mosi_o = !mosi_o;
  endtask
endmodule

// file: testbench/tb.sv
/* Bench for kpsr_top driven by the pad master model.
   Assumes the default 16 word buffer. */
`timescale 1ns/1ps
module tb;
  logic       clock_i = 1'b0, reset_i = 1'b1, port_en_i = 1'b0;
  logic [7:0] mode_i = 8'h00, packet_i = 8'h01, bufsize_i = 8'h02;
  logic       glob_en_set_i = 1'b0, glob_en_clr_i = 1'b0;
  logic       pad_en_set_i = 1'b0, pad_en_clr_i = 1'b0, rx_ready_i = 1'b1;
  logic       sck_i, ss_n_i, mosi_i, miso_o, miso_oe_o, sck_oe_o;
  logic       ss_oe_o, mosi_oe_o, rx_valid_o, drop_o, irq_o;
  logic       glob_en_o, pad_en_o;
  logic [7:0] rx_data_o, rx_count_o;
  int         mismatches = 0, cmp_count = 0, irq_n = 0, drop_n = 0;
  logic [7:0] rxq[$];
  always #2 clock_i = !clock_i;
  kpsr_top kpsr_top_i (
    .clock_i       (clock_i),
    .reset_i       (reset_i),
    .port_en_i     (port_en_i),
    .mode_i        (mode_i),
    .packet_i      (packet_i),
    .bufsize_i     (bufsize_i),
    .glob_en_set_i (glob_en_set_i),
    .glob_en_clr_i (glob_en_clr_i),
    .pad_en_set_i  (pad_en_set_i),
    .pad_en_clr_i  (pad_en_clr_i),
    .sck_i         (sck_i),
    .ss_n_i        (ss_n_i),
    .mosi_i        (mosi_i),
    .miso_o        (miso_o),
    .miso_oe_o     (miso_oe_o),
    .sck_oe_o      (sck_oe_o),
    .ss_oe_o       (ss_oe_o),
    .mosi_oe_o     (mosi_oe_o),
    .rx_valid_o    (rx_valid_o),
    .rx_ready_i    (rx_ready_i),
    .rx_data_o     (rx_data_o),
    .rx_count_o    (rx_count_o),
    .drop_o        (drop_o),
    .irq_o         (irq_o),
    .glob_en_o     (glob_en_o),
    .pad_en_o      (pad_en_o)
  );
  kpsr_pad_model kpsr_pad_model_i (.sck_o(sck_i), .ss_n_o(ss_n_i),
                                   .mosi_o(mosi_i));
  always @(negedge clock_i)
  begin
    if (rx_valid_o === 1'b1 && rx_ready_i) rxq.push_back(rx_data_o);
    if (irq_o === 1'b1) irq_n++;
    if (drop_o === 1'b1) drop_n++;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wait_rx(int n);
    for (int k = 0; k < 80 && rxq.size() < n; k++) @(posedge clock_i);
    if (rxq.size() < n)
    begin
      mismatches++;
      $display("[ERR] rx bytes exp %0d got %0d", n, rxq.size());
      end_of_test();
    end
  endtask
  task automatic cfg(logic [7:0] m, logic [7:0] p, logic [7:0] b);
    @(posedge clock_i);
    mode_i <= m;
    packet_i <= p;
    bufsize_i <= b;
  endtask
  task automatic en(logic [3:0] p);
    @(posedge clock_i);
    {glob_en_set_i, glob_en_clr_i, pad_en_set_i, pad_en_clr_i} <= p;
    @(posedge clock_i);
    {glob_en_set_i, glob_en_clr_i, pad_en_set_i, pad_en_clr_i} <= 4'h0;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    chk("glob_en", 8'h01, {7'h00, glob_en_o});
    chk("pad_en", 8'h01, {7'h00, pad_en_o});
    chk("oe", 8'h00, {5'h00, sck_oe_o, ss_oe_o, mosi_oe_o});
    chk("miso idle", 8'h00, {6'h00, miso_oe_o, miso_o});
  endtask
  task automatic s_modes();
    logic [7:0] m, d;
    for (int i = 0; i < 8; i++)
    begin
      m = {2'h0, i[2], 1'b0, i[1], i[0], 2'h0};
      d = 8'h16 + 8'h23 * i[7:0];
      cfg(m, 8'h01, 8'h02);
      kpsr_pad_model_i.send(d, m);
      wait_rx(1);
      chk("mode byte", d, rxq.pop_front());
      chk("irq", 8'(i + 1), 8'(irq_n));
    end
  endtask
  task automatic s_gate();
    logic [3:0] p[4] = '{4'h4, 4'h8, 4'h1, 4'h2};
    logic [7:0] e[4] = '{8'h00, 8'h01, 8'h00, 8'h01};
    int n;
    cfg(8'h00, 8'h01, 8'h02);
    for (int k = 0; k < 4; k++)
    begin
      en(p[k]);
      n = irq_n;
      kpsr_pad_model_i.send(8'hC3, 8'h00);
      wait_rx(1);
      chk("gate byte", 8'hC3, rxq.pop_front());
      chk("gated irq", e[k], 8'(irq_n - n));
    end
  endtask
  task automatic s_packet();
    int n;
    cfg(8'h00, 8'h03, 8'h04);
    n = irq_n;
    for (int k = 0; k < 3; k++)
    begin
      kpsr_pad_model_i.send(8'h5A, 8'h00);
      wait_rx(k + 1);
      chk("packet irq", {7'h00, k == 2}, 8'(irq_n - n));
    end
    rxq.delete();
  endtask
  task automatic s_full();
    int n;
    cfg(8'h20, 8'h03, 8'h04);
    rx_ready_i <= 1'b0;
    n = drop_n;
    for (int k = 0; k < 6; k++)
      kpsr_pad_model_i.send(8'(8'hA0 + k), 8'h20);
    @(posedge clock_i);
    chk("level", 8'h04, rx_count_o);
    chk("drops", 8'h02, 8'(drop_n - n));
    rx_ready_i <= 1'b1;
    wait_rx(4);
    for (int k = 0; k < 4; k++)
      chk("kept", 8'(8'hA0 + k), rxq[k]);
  endtask
  initial
  begin
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    port_en_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    s_reset();
    s_modes();
    s_gate();
    s_packet();
    s_full();
    end_of_test();
  end
endmodule
